// File: logic/ssl_pkg.sv
// Shared constants for the serial-to-parallel shift latch block
package ssl_pkg;
    // ------------------------------------------------------------------
    // Data path sizes
    // ------------------------------------------------------------------
    localparam int SSL_WIDTH       = 8;
    localparam int SSL_FIFO_DEPTH  = 16;
    localparam int SSL_CASCADE_IDX = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] SSL_STAGE_RST = 8'h00;
    localparam logic [7:0] SSL_LATCH_RST = 8'h00;
    localparam logic [7:0] SSL_CLEAR_VAL = 8'h00;

    // ------------------------------------------------------------------
    // Positions of the pin inputs in the synchroniser vector
    // ------------------------------------------------------------------
    localparam int SSL_PIN_SIN  = 0;
    localparam int SSL_PIN_SHCK = 1;
    localparam int SSL_PIN_STCK = 2;
    localparam int SSL_PIN_CLRN = 3;
    localparam int SSL_PIN_OEN  = 4;
    localparam int SSL_PIN_NUM  = 5;
    // Clocks idle low, clear and output enable idle inactive (high)
    localparam logic [4:0] SSL_PIN_RST = 5'h18;
endpackage

// File: logic/ssl_stream_if.sv
// Valid/ready word stream between the shift latch and its FIFO
`timescale 1ns/1ps
interface ssl_stream_if #(
    parameter int W = 8
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: logic/ssl_fifo.sv
// Word FIFO with registered read data for captured latch words
`timescale 1ns/1ps
module ssl_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // Clock and control
    input  wire logic              i_mclk,
    input  wire logic              i_rst_n,
    input  wire logic              i_ce,
    // Streams
    ssl_stream_if.snk              push,
    ssl_stream_if.src              pop,
    // Status
    output logic [$clog2(DEPTH):0] o_level
);
    import ssl_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // DEPTH must be a power of two so the pointers wrap on their own
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic [W-1:0]  out_data;
    logic          out_valid;

    wire do_wr   = push.valid & push.ready;
    wire do_rd   = (count != '0) & (~out_valid | pop.ready);
    wire out_clr = out_valid & pop.ready & ~do_rd;

    assign push.ready = (count != FULL_CNT);
    assign pop.valid  = out_valid;
    assign pop.data   = out_data;
    assign o_level    = count;

    // ------------------------------------------------------------------
    // Pointers and read register
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (i_ce) begin
            if (do_wr)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_rd) begin
                rd_ptr    <= rd_ptr + 1'b1;
                out_data  <= mem[rd_ptr];
                out_valid <= 1'b1;
            end else if (out_clr) begin
                out_valid <= 1'b0;
            end
            case ({do_wr, do_rd})
                2'b10:   count <= count + 1'b1;
                2'b01:   count <= count - 1'b1;
                default: count <= count;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_ce && do_wr)
            mem[wr_ptr] <= push.data;
    end
endmodule

// File: logic/ssl_shift_latch.sv
// Serial-in shift register with storage latch, three-state outputs and capture FIFO
//
// Behaviour
// - Eight shift stages feed an eight-bit storage latch whose parallel outputs can be switched off.
// - The shift stages and the latch each follow their own rising clock, independently.
// - Stages capture on a rising clock and the outputs show the new value from the next falling edge.
// - With both clocks tied together the latch holds the stage contents of one clock earlier.
// - A low clear forces all stages and the cascade output to zero and leaves the latch alone.
// - A rising storage clock while clear is low loads zeros into the latch.
// - A high output enable floats all eight parallel outputs while the cascade output stays driven.
// - A rising shift clock with clear inactive moves serial data into stage 0 and every stage up one.
// - A rising storage clock with clear inactive copies all stages into the latch; cascade is untouched.
// - When both clocks rise together the latch takes the stage contents from before the shift.
`timescale 1ns/1ps
module ssl_shift_latch #(
    parameter int WIDTH      = ssl_pkg::SSL_WIDTH,
    parameter int FIFO_DEPTH = ssl_pkg::SSL_FIFO_DEPTH
) (
    // Clock, reset, enable
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_ce,
    // Device pins in
    input  wire logic                          i_serial_in,
    input  wire logic                          i_shift_clock,
    input  wire logic                          i_storage_clock,
    input  wire logic                          i_shift_clear_n,
    input  wire logic                          i_output_enable_n,
    // Device pins out
    output logic [WIDTH-1:0]                   o_par_q,
    output logic [WIDTH-1:0]                   o_par_oe_n,
    output logic                               o_cascade,
    // Captured word stream
    output logic [WIDTH-1:0]                   o_word_data,
    output logic                               o_word_valid,
    input  wire logic                          i_word_ready,
    output logic                               o_capture_ready,
    output logic [$clog2(FIFO_DEPTH):0]        o_fifo_level,
    // Overflow status
    output logic                               o_overflow,
    input  wire logic                          i_overflow_clr
);
    import ssl_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Pins are asynchronous to i_mclk: two flops, then a history flop
    // for edge detection so the first flop feeds only the second.
    logic [SSL_PIN_NUM-1:0] pin_meta;
    logic [SSL_PIN_NUM-1:0] pin_sync;
    logic [SSL_PIN_NUM-1:0] pin_prev;

    wire [SSL_PIN_NUM-1:0] pin_raw = {i_output_enable_n, i_shift_clear_n,
                                      i_storage_clock, i_shift_clock, i_serial_in};

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pin_meta <= SSL_PIN_RST;
            pin_sync <= SSL_PIN_RST;
            pin_prev <= SSL_PIN_RST;
        end else if (i_ce) begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // ------------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------------
    function automatic logic rise_of(input logic [SSL_PIN_NUM-1:0] now_v,
                                     input logic [SSL_PIN_NUM-1:0] old_v,
                                     input int idx);
        rise_of = now_v[idx] & ~old_v[idx];
    endfunction

    function automatic logic fall_of(input logic [SSL_PIN_NUM-1:0] now_v,
                                     input logic [SSL_PIN_NUM-1:0] old_v,
                                     input int idx);
        fall_of = ~now_v[idx] & old_v[idx];
    endfunction

    wire sin_bit   = pin_sync[SSL_PIN_SIN];
    wire clr_act   = ~pin_sync[SSL_PIN_CLRN];
    wire oe_off    = pin_sync[SSL_PIN_OEN];
    // Each clock has its own detector, so the two never interact
    wire sh_rise   = rise_of(pin_sync, pin_prev, SSL_PIN_SHCK);
    wire sh_fall   = fall_of(pin_sync, pin_prev, SSL_PIN_SHCK);
    wire st_rise   = rise_of(pin_sync, pin_prev, SSL_PIN_STCK);
    wire st_fall   = fall_of(pin_sync, pin_prev, SSL_PIN_STCK);

    // ------------------------------------------------------------------
    // Shift stages
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] stage;
    logic [WIDTH-1:0] next_stage;

    // Clear dominates any shift edge seen in the same cycle
    assign next_stage = clr_act ? SSL_CLEAR_VAL :
                        sh_rise ? {stage[WIDTH-2:0], sin_bit} :
                                  stage;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n)
            stage <= SSL_STAGE_RST;
        else if (i_ce)
            stage <= next_stage;
    end

    // ------------------------------------------------------------------
    // Storage latch
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] next_latch;

    // Reads the stage flops before this cycle's shift lands, so a shared
    // clock leaves the latch one shift behind.
    assign next_latch = !st_rise ? latch :
                        clr_act  ? SSL_CLEAR_VAL :
                                   stage;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n)
            latch <= SSL_LATCH_RST;
        else if (i_ce)
            latch <= next_latch;
    end

    // ------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] par_q;
    logic             cas_q;
    logic [WIDTH-1:0] next_par_q;
    logic             next_cas_q;

    // New values appear on the falling half of each pin clock
    assign next_par_q = st_fall ? latch : par_q;
    // Clear reaches the cascade pin without waiting for a clock edge
    assign next_cas_q = clr_act ? 1'b0 :
                        sh_fall ? stage[SSL_CASCADE_IDX] : cas_q;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            par_q <= SSL_LATCH_RST;
            cas_q <= 1'b0;
        end else if (i_ce) begin
            par_q <= next_par_q;
            cas_q <= next_cas_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_par
            assign o_par_q[gi]    = par_q[gi];
            assign o_par_oe_n[gi] = oe_off;
        end
    endgenerate

    // Cascade has no enable term: it is always driven
    assign o_cascade = cas_q;

    // ------------------------------------------------------------------
    // Capture FIFO
    // ------------------------------------------------------------------
    // Every latch load is also queued for on-chip consumers. The pins must
    // behave exactly like the device, so a full FIFO cannot stall the latch;
    // the word is dropped and flagged instead.
    ssl_stream_if #(.W(WIDTH)) push_if ();
    ssl_stream_if #(.W(WIDTH)) pop_if ();

    assign push_if.valid = st_rise;
    assign push_if.data  = next_latch;
    assign pop_if.ready  = i_word_ready;

    ssl_fifo #(
        .W     (WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .push    (push_if),
        .pop     (pop_if),
        .o_level (o_fifo_level)
    );

    assign o_word_data     = pop_if.data;
    assign o_word_valid    = pop_if.valid;
    assign o_capture_ready = push_if.ready;

    // ------------------------------------------------------------------
    // Overflow flag
    // ------------------------------------------------------------------
    logic overflow;
    wire  ovf_set = st_rise & ~push_if.ready;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n)
            overflow <= 1'b0;
        else if (i_ce) begin
            // A drop in the clearing cycle still leaves the flag set
            if (ovf_set)
                overflow <= 1'b1;
            else if (i_overflow_clr)
                overflow <= 1'b0;
        end
    end

    assign o_overflow = overflow;
endmodule

// File: bench/ssl_latch_properties.sv
// Port-level checks for the shift latch
`timescale 1ns/1ps
module ssl_latch_properties #(
    parameter int WIDTH      = 8,
    parameter int FIFO_DEPTH = 16
) (
    // Clock, reset and pins
    input wire logic i_mclk, i_rst_n, i_ce, i_serial_in, i_shift_clock,
    input wire logic i_storage_clock, i_shift_clear_n, i_output_enable_n,
    // Outputs
    input wire logic [WIDTH-1:0] o_par_q, o_par_oe_n, o_word_data,
    input wire logic o_cascade, o_word_valid, o_capture_ready, o_overflow,
    input wire logic [$clog2(FIFO_DEPTH):0] o_fifo_level,
    // Stream controls
    input wire logic i_word_ready, i_overflow_clr
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // ----
    // Assertions
    // ----
    oe_follow_a: assert property (
        o_par_oe_n == {WIDTH{$past(i_output_enable_n, 2)}}) else $error("enable view wrong");
    cascade_cause_a: assert property ($changed(o_cascade) |->
        ($past(i_shift_clock, 4) && !$past(i_shift_clock, 3)) || !$past(i_shift_clear_n, 3))
        else $error("cascade moved without cause");
    par_cause_a: assert property ($changed(o_par_q) |->
        $past(i_storage_clock, 4) && !$past(i_storage_clock, 3)) else $error("parallel moved without cause");
    clear_zero_a: assert property (!$past(i_shift_clear_n, 3) |-> !o_cascade)
        else $error("cascade not cleared");
    ovf_set_a: assert property ($rose(o_overflow) |-> !$past(o_capture_ready)
        && $past(i_storage_clock, 3) && !$past(i_storage_clock, 4)) else $error("overflow without drop");
    ovf_hold_a: assert property (o_overflow && !i_overflow_clr |=> o_overflow) else $error("overflow lost");
    ready_level_a: assert property (o_capture_ready == (o_fifo_level != FIFO_DEPTH))
        else $error("ready disagrees with level");
    word_hold_a: assert property (o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word_data))
        else $error("head word not held");
    cover property ($rose(o_overflow));
    cover property (o_word_valid && i_word_ready);
    cover property (o_par_oe_n == '0 && o_par_q != '0);
endmodule

bind ssl_shift_latch ssl_latch_properties #(.WIDTH(WIDTH), .FIFO_DEPTH(FIFO_DEPTH)) chk (
    .i_mclk, .i_rst_n, .i_ce, .i_serial_in, .i_shift_clock, .i_storage_clock, .i_shift_clear_n,
    .i_output_enable_n, .o_par_q, .o_par_oe_n, .o_word_data, .o_cascade, .o_word_valid,
    .o_capture_ready, .o_overflow, .o_fifo_level, .i_word_ready, .i_overflow_clr);

// File: bench/ssl_pin_driver.sv
// Controller model driving the serial, clock, clear and enable pins
`timescale 1ns/1ps
module ssl_pin_driver (
    // Timing reference
    input  wire logic i_mclk,
    // Pins
    output logic      o_serial_in,
    output logic      o_shift_clock,
    output logic      o_storage_clock,
    output logic      o_shift_clear_n,
    output logic      o_output_enable_n
);
    initial begin
        o_serial_in = 1'b0;
        o_shift_clock = 1'b0;
        o_storage_clock = 1'b0;
        o_shift_clear_n = 1'b1;
        o_output_enable_n = 1'b1;
    end
    // Four cycles per level, above the two-cycle sampling minimum
    task automatic gap();
        repeat (4) @(negedge i_mclk);
    endtask
    task automatic pulse(input logic b, input logic sh, input logic st);
        o_serial_in <= b;
        gap();
        o_shift_clock <= sh;
        o_storage_clock <= st;
        gap();
        o_shift_clock <= 1'b0;
        o_storage_clock <= 1'b0;
        // Data no longer held: show the inverse so stale data is not mistaken
        o_serial_in <= ~b;
        gap();
    endtask
    task automatic level(input logic clr_n, input logic oe_n);
        o_shift_clear_n <= clr_n;
        o_output_enable_n <= oe_n;
        gap();
    endtask
endmodule

// File: bench/test_ssl_shift_latch.sv
// Self-checking bench for the serial-to-parallel shift latch
`timescale 1ns/1ps
module test_ssl_shift_latch;
    import ssl_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_word_ready = 1'b0;
    logic        i_overflow_clr = 1'b0;
    logic        rmode = 1'b0;
    logic        ce = 1'b1;
    logic        serial, shck, stck, clr_n, oe_n, cas, wv, crdy, ovf;
    logic [7:0]  pq, poe_n, wd, st = 8'h00, lat = 8'h00;
    logic [4:0]  lvl;
    wire  [7:0]  q_pin;
    logic [7:0]  exp_q[$];
    logic [31:0] rnd = 32'h3512;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    initial forever #2.5 i_mclk = ~i_mclk;
    for (genvar k = 0; k < 8; k++) begin : g_pin
        assign q_pin[k] = poe_n[k] ? 1'bz : pq[k];
    end
    ssl_pin_driver ctl (.i_mclk(i_mclk), .o_serial_in(serial), .o_shift_clock(shck), .o_storage_clock(stck),
        .o_shift_clear_n(clr_n), .o_output_enable_n(oe_n));
    ssl_shift_latch uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce), .i_serial_in(serial),
        .i_shift_clock(shck), .i_storage_clock(stck), .i_shift_clear_n(clr_n), .i_output_enable_n(oe_n),
        .o_par_q(pq), .o_par_oe_n(poe_n), .o_cascade(cas), .o_word_data(wd), .o_word_valid(wv),
        .i_word_ready(i_word_ready), .o_capture_ready(crdy), .o_fifo_level(lvl), .o_overflow(ovf),
        .i_overflow_clr(i_overflow_clr));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_word(input logic [7:0] got);
        check(got, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic shift();
        rnd = lfsr(rnd);
        if (rmode) i_word_ready <= rnd[5];
        ctl.pulse(rnd[0], 1'b1, 1'b0);
        st = clr_n ? {st[6:0], rnd[0]} : 8'h00;
        check({7'h00, cas}, {7'h00, st[7]});
    endtask
    task automatic store(input logic both);
        rnd = lfsr(rnd);
        lat = clr_n ? st : 8'h00;
        // The FIFO holds 17 words; later ones are dropped
        if (exp_q.size() < 17) exp_q.push_back(lat);
        ctl.pulse(rnd[0], both, 1'b1);
        if (both && clr_n) st = {st[6:0], rnd[0]};
        check(pq, lat);
        check(q_pin, oe_n ? 8'hzz : lat);
        check({7'h00, cas}, {7'h00, st[7]});
    endtask

    // Words are compared in the cycle they leave
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            conclude();
        end else if (i_rst_n && ce && wv && i_word_ready) begin
            check_word(wd);
        end
    end

    initial begin
        repeat (3) @(negedge i_mclk);
        i_rst_n <= 1'b1;
        @(negedge i_mclk);
        check(pq, 8'h00);
        check(poe_n, 8'hff);
        check({cas, wv, crdy, ovf, lvl[3:0]}, 8'h20);
        ctl.level(1'b1, 1'b0);
        rmode = 1'b1;
        repeat (4) begin
            repeat (8) shift();
            store(1'b0);
        end
        // Clock enable low: a whole pin pulse passes unseen and nothing moves
        ce <= 1'b0;
        ctl.pulse(1'b1, 1'b1, 1'b1);
        ce <= 1'b1;
        check({7'h00, cas}, {7'h00, st[7]});
        check(pq, lat);
        repeat (3) store(1'b1);
        ctl.level(1'b1, 1'b1);
        repeat (3) shift();
        store(1'b0);
        ctl.level(1'b0, 1'b0);
        st = 8'h00;
        check(pq, lat);
        check({7'h00, cas}, 8'h00);
        shift();
        store(1'b0);
        ctl.level(1'b1, 1'b0);
        rmode = 1'b0;
        i_word_ready <= 1'b1;
        for (int i = 0; i < 100 && exp_q.size() > 0; i++) @(negedge i_mclk);
        i_word_ready <= 1'b0;
        repeat (18) begin
            shift();
            store(1'b0);
        end
        check({1'b0, crdy, ovf, lvl}, 8'h30);
        i_word_ready <= 1'b1;
        for (int i = 0; i < 100 && exp_q.size() > 0; i++) @(negedge i_mclk);
        @(negedge i_mclk);
        check({wv, ovf, 1'b0, lvl}, 8'h40);
        i_overflow_clr <= 1'b1;
        @(negedge i_mclk);
        i_overflow_clr <= 1'b0;
        @(negedge i_mclk);
        check({7'h00, ovf}, 8'h00);
        conclude();
    end
endmodule
